// ===== hw/intensity_params.svh
/*
  Constants for the per-port intensity registers: offsets, field positions, reset values.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef INTENSITY_PARAMS_SVH
`define INTENSITY_PARAMS_SVH

// Register offsets
`define OFS_PORT1_PORT0 8'h10
`define OFS_PORT3_PORT2 8'h11
`define OFS_PORT5_PORT4 8'h12
`define OFS_PORT7_PORT6 8'h13

// Field positions inside a register
`define LOW_CODE_LSB 0
`define HIGH_CODE_LSB 4

// Reset values and unmapped read value
`define INTENSITY_RESET 8'h00
`define READ_RESET 8'h00
`define UNMAPPED_READ 8'h00

// Codes
`define CODE_STATIC 4'hf
`define MASTER_OFF 4'h0

// Timing counts
`define PHASE_RESET 4'h0
`define PHASE_STEP 4'h1

// Output levels
`define PORTS_RESET 8'h00
`define PORTS_STATIC 8'hff

`endif

// ===== hw/intensity_pkg.sv
/*
  Types for the per-port intensity block.
  Assumes the params header is on the include path.
*/
`include "intensity_params.svh"

package intensity_pkg;
  typedef logic [3:0] code_t;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] phase_t;
endpackage : intensity_pkg

// ===== hw/per_port_led_intensity_regs.sv
/*
  Four byte-wide intensity registers holding one 4-bit code per port, and the PWM for
  eight ports plus the ninth output.
  Assumes a serial protocol engine on CORE_CLK presents decoded register accesses, and the
  master intensity register supplies the master value and the ninth output's code.
*/
//
// Summary of operation
// (R01) Codes 0 to 14 give duty of (code+1)/16 on the port.
// (R02) All-ones code holds the port statically on, no PWM.
// (R03) Register 0x10 holds port one code high, port zero code low.
// (R04) Reads return stored codes in the bit positions written.
// (R05) Register 0x11 holds port three high, port two low, read/write.
// (R06) Register 0x12 holds port five high, port four low, read/write.
// (R07) Register 0x13 holds port seven high, port six low, read/write.
// (R08) Ninth output code comes from master register low nibble, same encoding.
// (R09) Master value zero stops the PWM counter and holds outputs static.
// (R10) Bus master sends register address as command byte before data.
`timescale 1ns/10ps
`include "intensity_params.svh"

module per_port_led_intensity_regs (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire intensity_pkg::byte_t REG_ADDR,
  input wire intensity_pkg::byte_t REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output intensity_pkg::byte_t REG_RDATA,
  input wire intensity_pkg::code_t MASTER_CODE,
  input wire intensity_pkg::code_t NINTH_CODE,
  output logic [7:0] PORT_ON,
  output logic NINTH_ON,
  output logic OSC_RUN
);
  import intensity_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  byte_t p10_reg;
  byte_t p32_reg;
  byte_t p54_reg;
  byte_t p76_reg;
  phase_t phase_reg;
  phase_t phase_next;
  logic master_on;
  logic [3:0] wr_sel;
  logic [3:0] rd_sel;
  byte_t rdata_next;
  logic [7:0] port_next;
  logic ninth_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // (R01) Duty of code plus one
  // (R02) All ones static
  function automatic logic duty_on(input code_t code, input phase_t phase);
    duty_on = (code == `CODE_STATIC) ? 1'b1 : (phase <= code);
  endfunction : duty_on

  // One-hot register select
  function automatic logic [3:0] reg_select(input byte_t addr);
    case (addr)
      // (R03) Port one and zero
      `OFS_PORT1_PORT0: reg_select = 4'h1;
      // (R05) Port three and two
      `OFS_PORT3_PORT2: reg_select = 4'h2;
      // (R06) Port five and four
      `OFS_PORT5_PORT4: reg_select = 4'h4;
      // (R07) Port seven and six
      `OFS_PORT7_PORT6: reg_select = 4'h8;
      default: reg_select = 4'h0;
    endcase
  endfunction : reg_select

  // Even port code, low nibble
  function automatic code_t low_code(input byte_t value);
    low_code = value[`LOW_CODE_LSB +: 4];
  endfunction : low_code

  // Odd port code, high nibble
  function automatic code_t high_code(input byte_t value);
    high_code = value[`HIGH_CODE_LSB +: 4];
  endfunction : high_code

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign master_on = (MASTER_CODE != `MASTER_OFF);
  assign wr_sel = (CE && REG_WE) ? reg_select(REG_ADDR) : 4'h0;
  assign rd_sel = reg_select(REG_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  // (R03) Port one and zero
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      p10_reg <= `INTENSITY_RESET;
    end else if (wr_sel[0]) begin
      p10_reg <= REG_WDATA;
    end
  end

  // (R05) Port three and two
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      p32_reg <= `INTENSITY_RESET;
    end else if (wr_sel[1]) begin
      p32_reg <= REG_WDATA;
    end
  end

  // (R06) Port five and four
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      p54_reg <= `INTENSITY_RESET;
    end else if (wr_sel[2]) begin
      p54_reg <= REG_WDATA;
    end
  end

  // (R07) Port seven and six
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      p76_reg <= `INTENSITY_RESET;
    end else if (wr_sel[3]) begin
      p76_reg <= REG_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  // (R04) Read back stored
  always_comb begin
    case (rd_sel)
      4'h1: rdata_next = p10_reg;
      4'h2: rdata_next = p32_reg;
      4'h4: rdata_next = p54_reg;
      4'h8: rdata_next = p76_reg;
      default: rdata_next = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= `READ_RESET;
    end else if (CE && REG_RE) begin
      REG_RDATA <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM phase counter
  // (R09) Stop when master off
  always_comb begin
    if (master_on) begin
      phase_next = phase_reg + `PHASE_STEP;
    end else begin
      phase_next = `PHASE_RESET;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_reg <= `PHASE_RESET;
    end else if (CE) begin
      phase_reg <= phase_next;
    end
  end

  // (R09) Counter run flag
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OSC_RUN <= 1'b0;
    end else if (CE) begin
      OSC_RUN <= master_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output compare
  // (R01) Duty of code plus one
  // (R02) All ones static
  always_comb begin
    port_next[0] = duty_on(low_code(p10_reg), phase_reg);
    port_next[1] = duty_on(high_code(p10_reg), phase_reg);
    port_next[2] = duty_on(low_code(p32_reg), phase_reg);
    port_next[3] = duty_on(high_code(p32_reg), phase_reg);
    port_next[4] = duty_on(low_code(p54_reg), phase_reg);
    port_next[5] = duty_on(high_code(p54_reg), phase_reg);
    port_next[6] = duty_on(low_code(p76_reg), phase_reg);
    port_next[7] = duty_on(high_code(p76_reg), phase_reg);
  end

  // (R08) Ninth from master register
  assign ninth_next = duty_on(NINTH_CODE, phase_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Output drive
  // Port drive
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PORT_ON <= `PORTS_RESET;
    end else if (CE) begin
      if (master_on) begin
        PORT_ON <= port_next;
      end else begin
        // (R09) Static, codes ignored
        PORT_ON <= `PORTS_STATIC;
      end
    end
  end

  // Ninth drive
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      NINTH_ON <= 1'b0;
    end else if (CE) begin
      if (master_on) begin
        NINTH_ON <= ninth_next;
      end else begin
        // (R09) Ninth static too
        NINTH_ON <= 1'b1;
      end
    end
  end

endmodule : per_port_led_intensity_regs

// ===== sim/bus_master.sv
/* Bus master model making register accesses.
   Assumes CORE_CLK and the block's read data. */
`timescale 1ns/10ps
module bus_master (
  input wire logic clk,
  input wire intensity_pkg::byte_t rdata,
  output intensity_pkg::byte_t addr,
  output intensity_pkg::byte_t wdata,
  output logic we,
  output logic re
);
  import intensity_pkg::*;
  initial {addr, wdata, we, re} = '0;
  task automatic xfer(input byte_t a, input byte_t d, input logic w, output byte_t q);
    @(posedge clk);
    #1 {addr, wdata, we, re} = {a, d, w, !w};
    @(posedge clk);
    #1 {we, re, wdata} = {2'b00, ~d};
    q = rdata;
  endtask : xfer
endmodule : bus_master

// ===== sim/intensity_properties.sv
/* Port checker for the intensity block.
   Assumes one clock; bound below. */
`timescale 1ns/10ps
module intensity_properties (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire intensity_pkg::byte_t REG_ADDR,
  input wire intensity_pkg::byte_t REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire intensity_pkg::byte_t REG_RDATA,
  input wire intensity_pkg::code_t MASTER_CODE,
  input wire intensity_pkg::code_t NINTH_CODE,
  input wire logic [7:0] PORT_ON,
  input wire logic NINTH_ON,
  input wire logic OSC_RUN
);
  import intensity_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN || !CE);
  a_master_static: assert property (MASTER_CODE == 4'h0 |=> PORT_ON == 8'hff && NINTH_ON)
    else $error("outputs not static");
  a_osc_stop: assert property (MASTER_CODE == 4'h0 |=> !OSC_RUN)
    else $error("counter not stopped");
  a_osc_run: assert property (MASTER_CODE != 4'h0 |=> OSC_RUN)
    else $error("counter not running");
  a_ninth_static: assert property (NINTH_CODE == 4'hf |=> NINTH_ON)
    else $error("ninth not static");
  a_ninth_pulse: assert property (NINTH_ON && OSC_RUN && $past(CE) && NINTH_CODE == 4'h0
    && $past(NINTH_CODE) == 4'h0 && MASTER_CODE != 4'h0 |=> !NINTH_ON) else $error("ninth pulse too long");
  a_unmapped_zero: assert property (REG_RE && REG_ADDR[7:2] != 6'h04 |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!REG_RE |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_write_readback: assert property (REG_WE && REG_ADDR[7:2] == 6'h04 ##1 !REG_WE ##1 REG_RE && !REG_WE
    && REG_ADDR == $past(REG_ADDR, 2) |=> REG_RDATA == $past(REG_WDATA, 3)) else $error("readback wrong");
endmodule : intensity_properties
bind per_port_led_intensity_regs intensity_properties chk (.*);

// ===== sim/testbench.sv
/* Testbench: register access and PWM duty checks.
   Assumes design, checker and master model compiled first. */
`timescale 1ns/10ps
module testbench;
  import intensity_pkg::*;
  logic CORE_CLK = 0;
  logic RESETN = 0;
  code_t MASTER_CODE = 4'h1;
  code_t NINTH_CODE = 4'h0;
  byte_t REG_ADDR, REG_WDATA, REG_RDATA, q;
  logic REG_WE, REG_RE, NINTH_ON, OSC_RUN;
  logic [7:0] PORT_ON;
  int failures = 0;
  int check_count = 0;
  int c;
  logic CE = 1'b1;
  byte_t held;
  byte_t cnt [9];
  always #50 CORE_CLK = ~CORE_CLK;
  per_port_led_intensity_regs dut (.CORE_CLK, .RESETN, .CE, .REG_ADDR, .REG_WDATA, .REG_WE,
    .REG_RE, .REG_RDATA, .MASTER_CODE, .NINTH_CODE, .PORT_ON, .NINTH_ON, .OSC_RUN);
  bus_master bm (.clk(CORE_CLK), .rdata(REG_RDATA), .addr(REG_ADDR), .wdata(REG_WDATA), .we(REG_WE),
    .re(REG_RE));
  task automatic chk(input string name, input byte_t exp, input byte_t got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic final_report();
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    #1000000 failures++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge CORE_CLK);
    #1 RESETN = 1;
    for (int a = 8'h0e; a < 8'h15; a++) begin
      bm.xfer(byte_t'(a), 8'h00, 0, q);
      chk("reset read", 8'h00, q);
      bm.xfer(byte_t'(a), byte_t'(a * 11), 1, q);
      bm.xfer(byte_t'(a), 8'h00, 0, q);
      chk("readback", (a >> 2) == 4 ? byte_t'(a * 11) : 8'h00, q);
    end
    for (int n = 0; n < 16; n++) begin
      NINTH_CODE = code_t'(n);
      for (int a = 8'h10; a < 8'h14; a++) bm.xfer(byte_t'(a), {code_t'(n), code_t'(15 - n)}, 1, q);
      cnt = '{default: 8'h00};
      repeat (2) @(posedge CORE_CLK);
      repeat (16) begin
        @(posedge CORE_CLK);
        #1;
        for (int b = 0; b < 9; b++) cnt[b] += (b == 8) ? NINTH_ON : PORT_ON[b % 8];
      end
      for (int b = 0; b < 9; b++) begin
        c = (b % 2 == 1 || b == 8) ? n : 15 - n;
        chk("duty count", byte_t'(c == 15 ? 16 : c + 1), cnt[b]);
      end
    end
    CE = 1'b0;
    held = PORT_ON;
    bm.xfer(8'h10, 8'h5a, 1, q);
    chk("frozen ports", held, PORT_ON);
    CE = 1'b1;
    bm.xfer(8'h10, 8'h00, 0, q);
    chk("frozen write", 8'hf0, q);
    MASTER_CODE = 4'h0;
    repeat (2) @(posedge CORE_CLK);
    #1 chk("static ports", 8'hff, PORT_ON);
    chk("ninth and counter", 8'h02, {6'h00, NINTH_ON, OSC_RUN});
    final_report();
  end
endmodule : testbench
